// [hdl/pcp_dev_end.sv]
// Functional notes
// [RL1] Management bits move with station clock
// [RL2] Data line open-drain, released when idle
// [RL3] Default interrupt pulls low when active
// [RL4] Interrupt triggers start disabled
// [RL5] Event flags stick until software clears
// [RL6] Polarity bit makes interrupt active-high
// [RL7] Station reads four status registers
// [RL8] Long reset pin low starts reset
// [RL9] Reset returns registers to defaults
// [RL10] Straps resampled at reset release
// [RL11] Sleep releases hold output, else high
// [RL12] Wake pulse leaves sleep state
// [RL13] Station address from strap level
// [RL14] Core timed from reference clock; the code counts CLK_HZ (40 MHz) cycles, not REF_CLK_HZ (25 MHz)
// [RL15] Link lamp, activity lamp blinks
// [RL16] Wake synchronised, short pulses ignored
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pcp_dev_end #(
   parameter int BLINK_CYC = pcp_pkg::BLINK_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   pcp_link_if.dev lnk,
   input wire logic [pcp_pkg::EVT_W-1:0] evt_in,
   input wire logic link_up,
   input wire logic activity,
   input wire logic sleep_req,
   input wire logic addr_strap_pin,
   output logic irq,
   output logic link_lamp,
   output logic activity_lamp,
   output logic in_sleep,
   output logic pin_reset_active,
   output logic [4:0] station_addr_bits
);
   import pcp_pkg::*;

   localparam int RS_W = $clog2(RST_MIN_CYC + 1);
   localparam int WK_W = $clog2(WAKE_MIN_CYC + 1);
   localparam int BL_W = $clog2(BLINK_CYC + 1);

   logic [1:0] mdc_s, mdio_s, rstp_s, wake_s, strap_s;
   logic mdc_d;
   logic mdc_rise;
   logic b;
   logic [RS_W-1:0] rlow_reg;
   logic hold_reg;
   logic rel;
   logic strap_ok_reg;
   logic [1:0] strap_fill_reg;
   logic [4:0] addr_reg;
   logic pol_reg;
   logic [EVT_W-1:0] en_reg, stat_reg, clr;
   logic act;
   logic irq_reg, int_oe_reg, int_o_reg;
   pcp_pwr_t pwr_reg;
   logic [WK_W-1:0] wk_reg;
   logic hold_oe_reg, hold_o_reg;
   logic [BL_W-1:0] bl_cnt_reg;
   logic blink_reg, link_lamp_reg, act_lamp_reg;
   pcp_mf_t mf_reg;
   logic [3:0] cnt_reg;
   logic [11:0] hdr_reg;
   logic [11:0] hdr_next;
   logic [15:0] rsh_reg, wsh_reg, rd_val;
   logic rd_reg, wr_reg;
   logic mdio_oe_reg, mdio_o_reg;
   logic wr_go_reg;
   logic [4:0] wr_addr_reg;
   logic [15:0] wr_data_reg;

   // Two-flop synchronisers for every pin
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mdc_s <= 2'h0;
         mdio_s <= 2'h3;
         rstp_s <= 2'h3;
         wake_s <= 2'h0;
         strap_s <= 2'h0;
         mdc_d <= 1'b0;
      end
      else
      begin
         mdc_s <= {mdc_s[0], lnk.mdc};
         mdio_s <= {mdio_s[0], lnk.mdio_line};
         rstp_s <= {rstp_s[0], lnk.rst_pin_n};
         wake_s <= {wake_s[0], lnk.wake_pin};
         strap_s <= {strap_s[0], addr_strap_pin};
         mdc_d <= mdc_s[1];
      end
   end

   // [RL1] Sample on station clock rise
   assign mdc_rise = mdc_s[1] & ~mdc_d;
   assign b = mdio_s[1];
   assign rel = hold_reg & rstp_s[1];

   // [RL8] Reset pin low-time qualifier
   // [RL14] Core clock counts the minimum
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rlow_reg <= '0;
         hold_reg <= 1'b0;
      end
      else if (!rstp_s[1])
      begin
         if (rlow_reg != RS_W'(RST_MIN_CYC))
            rlow_reg <= rlow_reg + 1'b1;
         if (rlow_reg == RS_W'(RST_MIN_CYC - 1))
            hold_reg <= 1'b1;
      end
      else
      begin
         rlow_reg <= '0;
         hold_reg <= 1'b0;
      end
   end

   // [RL10] Strap capture after any reset
   // [RL13] Address low bit from strap
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strap_fill_reg <= 2'h0;
         strap_ok_reg <= 1'b0;
         addr_reg <= 5'h00;
      end
      else
      begin
         // Waits until the synchroniser holds the pin
         strap_fill_reg <= {strap_fill_reg[0], 1'b1};
         if ((strap_fill_reg[1] && !strap_ok_reg) || rel)
         begin
            strap_ok_reg <= 1'b1;
            addr_reg <= {ADDR_BASE, strap_s[1]};
         end
      end
   end

   // Write-one-to-clear mask for status
   assign clr = (wr_go_reg && wr_addr_reg == REG_INT_STAT) ? wr_data_reg[EVT_W-1:0] : '0;

   // Interrupt configuration and sticky flags
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pol_reg <= 1'b0;
         en_reg <= '0;
         stat_reg <= '0;
      end
      // [RL9] Pin reset restores defaults
      else if (hold_reg)
      begin
         pol_reg <= 1'b0;
         en_reg <= '0;
         stat_reg <= '0;
      end
      else
      begin
         // [RL5] Set wins over clear
         stat_reg <= (stat_reg & ~clr) | evt_in;
         // [RL4] Enables written by software
         if (wr_go_reg && wr_addr_reg == REG_INT_EN)
            en_reg <= wr_data_reg[EVT_W-1:0];
         // [RL6] Polarity select
         if (wr_go_reg && wr_addr_reg == REG_INT_CFG)
            pol_reg <= wr_data_reg[CFG_POL_BIT];
      end
   end

   // [RL4] Only enabled flags count
   assign act = |(stat_reg & en_reg);

   // [RL3] Pull low when active, else release
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_reg <= 1'b0;
         int_oe_reg <= 1'b0;
         int_o_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= act;
         int_o_reg <= 1'b0;
         // [RL6] Inverted: pull low while inactive
         int_oe_reg <= pol_reg ? ~act : act;
      end
   end

   // [RL16] Wake width filter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wk_reg <= '0;
      else if (!wake_s[1])
         wk_reg <= '0;
      else if (wk_reg != WK_W'(WAKE_MIN_CYC))
         wk_reg <= wk_reg + 1'b1;
   end

   // Power state and hold output
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwr_reg <= PW_AWAKE;
         hold_oe_reg <= 1'b1;
         hold_o_reg <= 1'b1;
      end
      else
      begin
         hold_o_reg <= 1'b1;
         case (pwr_reg)
            PW_AWAKE:
            begin
               hold_oe_reg <= ~sleep_req;
               if (sleep_req && !hold_reg)
                  pwr_reg <= PW_SLEEP;
            end
            PW_SLEEP:
            begin
               // [RL12] Qualified wake pulse exits
               if (wk_reg == WK_W'(WAKE_MIN_CYC) || hold_reg)
               begin
                  pwr_reg <= PW_AWAKE;
                  hold_oe_reg <= 1'b1;
               end
               else
                  // [RL11] Released during sleep
                  hold_oe_reg <= 1'b0;
            end
            default:
               pwr_reg <= PW_AWAKE;
         endcase
      end
   end

   // [RL15] Lamps with activity blink
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bl_cnt_reg <= '0;
         blink_reg <= 1'b0;
         link_lamp_reg <= 1'b0;
         act_lamp_reg <= 1'b0;
      end
      else
      begin
         if (bl_cnt_reg == BL_W'(BLINK_CYC - 1))
         begin
            bl_cnt_reg <= '0;
            blink_reg <= ~blink_reg;
         end
         else
            bl_cnt_reg <= bl_cnt_reg + 1'b1;
         link_lamp_reg <= link_up;
         act_lamp_reg <= link_up & ~(activity & blink_reg);
      end
   end

   // Read data mux for the management port
   // [RL7] Status registers the station reads
   always_comb
   begin
      rd_val = 16'h0000;
      if (hdr_next[4:0] == REG_INT_CFG)
         rd_val = {15'h0000, pol_reg};
      else if (hdr_next[4:0] == REG_INT_STAT)
         rd_val = {{(16 - EVT_W){1'b0}}, stat_reg};
      else if (hdr_next[4:0] == REG_INT_EN)
         rd_val = {{(16 - EVT_W){1'b0}}, en_reg};
      else if (hdr_next[4:0] == REG_DEV_STAT)
         rd_val = {8'h00, act, in_sleep, link_up, addr_reg};
   end

   assign hdr_next = {hdr_reg[10:0], b};

   // Management frame receiver and responder
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mf_reg <= MF_IDLE;
         cnt_reg <= 4'h0;
         hdr_reg <= 12'h000;
         rsh_reg <= 16'h0000;
         wsh_reg <= 16'h0000;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         mdio_oe_reg <= 1'b0;
         mdio_o_reg <= 1'b0;
         wr_go_reg <= 1'b0;
         wr_addr_reg <= 5'h00;
         wr_data_reg <= 16'h0000;
      end
      else
      begin
         wr_go_reg <= 1'b0;
         mdio_o_reg <= 1'b0;
         if (hold_reg)
         begin
            mf_reg <= MF_IDLE;
            mdio_oe_reg <= 1'b0;
         end
         else if (mdc_rise)
         begin
            case (mf_reg)
               MF_IDLE:
                  if (!b)
                     mf_reg <= MF_ST;
               MF_ST:
               begin
                  cnt_reg <= 4'h0;
                  mf_reg <= b ? MF_HDR : MF_IDLE;
               end
               MF_HDR:
               begin
                  hdr_reg <= hdr_next;
                  cnt_reg <= cnt_reg + 1'b1;
                  if (cnt_reg == 4'hB)
                  begin
                     rd_reg <= hdr_next[11:10] == OP_RD && hdr_next[9:5] == addr_reg;
                     wr_reg <= hdr_next[11:10] == OP_WR && hdr_next[9:5] == addr_reg;
                     rsh_reg <= rd_val;
                     cnt_reg <= 4'h0;
                     mf_reg <= MF_TA;
                  end
               end
               MF_TA:
               begin
                  cnt_reg <= cnt_reg + 1'b1;
                  // [RL2] Pull low only for zero bits
                  if (cnt_reg == 4'h0)
                     mdio_oe_reg <= rd_reg;
                  else
                  begin
                     mdio_oe_reg <= rd_reg & ~rsh_reg[15];
                     rsh_reg <= {rsh_reg[14:0], 1'b0};
                     cnt_reg <= 4'h0;
                     mf_reg <= MF_DATA;
                  end
               end
               MF_DATA:
               begin
                  wsh_reg <= {wsh_reg[14:0], b};
                  rsh_reg <= {rsh_reg[14:0], 1'b0};
                  mdio_oe_reg <= rd_reg & ~rsh_reg[15];
                  cnt_reg <= cnt_reg + 1'b1;
                  if (cnt_reg == 4'hF)
                  begin
                     // [RL2] Release after last bit
                     mdio_oe_reg <= 1'b0;
                     wr_go_reg <= wr_reg;
                     wr_addr_reg <= hdr_reg[4:0];
                     wr_data_reg <= {wsh_reg[14:0], b};
                     mf_reg <= MF_IDLE;
                  end
               end
               default:
                  mf_reg <= MF_IDLE;
            endcase
         end
      end
   end

   // Pin and user outputs
   assign lnk.dev_mdio_o = mdio_o_reg;
   assign lnk.dev_mdio_oe = mdio_oe_reg;
   assign lnk.dev_int_o = int_o_reg;
   assign lnk.dev_int_oe = int_oe_reg;
   assign lnk.hold_o = hold_o_reg;
   assign lnk.hold_oe = hold_oe_reg;
   assign irq = irq_reg;
   assign link_lamp = link_lamp_reg;
   assign activity_lamp = act_lamp_reg;
   assign in_sleep = pwr_reg == PW_SLEEP;
   assign pin_reset_active = hold_reg;
   assign station_addr_bits = addr_reg;
endmodule // pcp_dev_end

// [common/pcp_pkg.sv]
package pcp_pkg;
   // Clock rates
   localparam int CLK_HZ = 40_000_000;
   localparam int REF_CLK_HZ = 25_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;

   // Least time in ns to whole clock cycles, rounded up
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   // Timing figures and their cycle counts
   localparam int RST_MIN_NS = 10_000;
   localparam int RST_MIN_CYC = ns_to_cyc(RST_MIN_NS);
   localparam int WAKE_MIN_NS = 1_000;
   localparam int WAKE_MIN_CYC = ns_to_cyc(WAKE_MIN_NS);
   localparam int WAKE_PULSE_NS = 2_000;
   localparam int WAKE_PULSE_CYC = ns_to_cyc(WAKE_PULSE_NS);
   localparam int MDC_HALF_NS = 250;
   localparam int MDC_HALF_CYC = ns_to_cyc(MDC_HALF_NS);
   localparam int BLINK_US = 50_000;
   localparam int BLINK_CYC = BLINK_US * CLK_MHZ;

   // Management frame layout
   localparam int FRAME_BITS = 64;
   localparam int DATA_START = 48;
   localparam logic [1:0] FR_ST = 2'h1;
   localparam logic [1:0] OP_RD = 2'h2;
   localparam logic [1:0] OP_WR = 2'h1;
   localparam logic [31:0] PREAMBLE = 32'hFFFF_FFFF;

   // Device registers on the management port
   localparam logic [4:0] REG_INT_CFG = 5'h11;
   localparam logic [4:0] REG_INT_STAT = 5'h12;
   localparam logic [4:0] REG_INT_EN = 5'h13;
   localparam logic [4:0] REG_DEV_STAT = 5'h18;
   localparam logic [3:0] ADDR_BASE = 4'h0;
   localparam int EVT_W = 8;
   localparam int CFG_POL_BIT = 0;

   // Station registers on the software port
   localparam logic [7:0] H_CMD = 8'h00;
   localparam logic [7:0] H_STAT = 8'h04;
   localparam logic [7:0] H_IRQ = 8'h08;
   localparam logic [7:0] H_MASK = 8'h0C;
   localparam logic [7:0] H_PIN = 8'h10;
   localparam int CMD_REG_LSB = 16;
   localparam int CMD_WR_BIT = 21;
   localparam int CMD_PHY_LSB = 22;
   localparam int STAT_BUSY_BIT = 16;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_DEV = 1;
   localparam int PIN_RST = 0;
   localparam int PIN_WAKE = 1;
   localparam int PIN_POL = 2;

   typedef enum logic [2:0] {
      MF_IDLE = 3'b000,
      MF_ST = 3'b001,
      MF_HDR = 3'b010,
      MF_TA = 3'b011,
      MF_DATA = 3'b100
   } pcp_mf_t;

   typedef enum logic {
      PW_AWAKE = 1'b0,
      PW_SLEEP = 1'b1
   } pcp_pwr_t;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_LOW = 2'b01,
      HS_HIGH = 2'b10
   } pcp_hs_t;
endpackage

// [common/pcp_link_if.sv]
`timescale 1ns/1ps
interface pcp_link_if;
   logic mdc;
   logic sta_mdio_o;
   logic sta_mdio_oe;
   logic dev_mdio_o;
   logic dev_mdio_oe;
   logic mdio_line;
   logic dev_int_o;
   logic dev_int_oe;
   logic int_line;
   logic rst_pin_n;
   logic wake_pin;
   logic hold_o;
   logic hold_oe;
   logic hold_line;

   // Open-drain data with pull-up
   assign mdio_line = ~((sta_mdio_oe & ~sta_mdio_o) | (dev_mdio_oe & ~dev_mdio_o));
   // Open-drain interrupt with weak pull-up
   assign int_line = ~(dev_int_oe & ~dev_int_o);
   // High-side output with external pull-down
   assign hold_line = hold_oe & hold_o;

   modport dev (
      input mdc, mdio_line, rst_pin_n, wake_pin,
      output dev_mdio_o, dev_mdio_oe, dev_int_o, dev_int_oe, hold_o, hold_oe
   );
   modport sta (
      input mdio_line, int_line, hold_line,
      output mdc, sta_mdio_o, sta_mdio_oe, rst_pin_n, wake_pin
   );
endinterface

// [hdl/pcp_sta_end.sv]
`timescale 1ns/1ps
module pcp_sta_end (
   input wire logic clk,
   input wire logic rst_n,
   pcp_link_if.sta lnk,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic irq
);
   import pcp_pkg::*;

   localparam int RS_W = $clog2(RST_MIN_CYC + 1);
   localparam int WK_W = $clog2(WAKE_PULSE_CYC + 1);
   localparam int PH_W = $clog2(MDC_HALF_CYC + 1);

   logic [1:0] mdio_s, int_s;
   pcp_hs_t hs_reg;
   logic [PH_W-1:0] ph_reg;
   logic [5:0] idx_reg;
   logic [FRAME_BITS-1:0] fr_reg;
   logic [15:0] rdat_reg;
   logic mdc_reg, oe_reg;
   logic done;
   logic [1:0] stat_reg, mask_reg, clr, set;
   logic pol_reg;
   logic [RS_W-1:0] rst_cnt_reg;
   logic [WK_W-1:0] wk_cnt_reg;
   logic [31:0] rdata_reg;
   logic irq_reg;
   logic start;
   logic dev_act;

   // Two-flop synchronisers for returning pins
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mdio_s <= 2'h3;
         int_s <= 2'h3;
      end
      else
      begin
         mdio_s <= {mdio_s[0], lnk.mdio_line};
         int_s <= {int_s[0], lnk.int_line};
      end
   end

   assign start = wr && addr == H_CMD && hs_reg == HS_IDLE;

   // [RL1] Frame engine makes the clock
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hs_reg <= HS_IDLE;
         ph_reg <= '0;
         idx_reg <= 6'h00;
         fr_reg <= '0;
         rdat_reg <= 16'h0000;
         mdc_reg <= 1'b0;
         oe_reg <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (hs_reg)
            HS_IDLE:
               if (start)
               begin
                  fr_reg <= {PREAMBLE, FR_ST, wdata[CMD_WR_BIT] ? OP_WR : OP_RD,
                     wdata[CMD_PHY_LSB +: 5], wdata[CMD_REG_LSB +: 5],
                     wdata[CMD_WR_BIT] ? {2'h2, wdata[15:0]} : 18'h3_FFFF};
                  // [RL2] Pull low only for zero bits
                  oe_reg <= 1'b0;
                  idx_reg <= 6'h00;
                  ph_reg <= '0;
                  hs_reg <= HS_LOW;
               end
            HS_LOW:
            begin
               oe_reg <= ~fr_reg[FRAME_BITS-1];
               ph_reg <= ph_reg + 1'b1;
               if (ph_reg == PH_W'(MDC_HALF_CYC - 1))
               begin
                  ph_reg <= '0;
                  mdc_reg <= 1'b1;
                  hs_reg <= HS_HIGH;
                  if (idx_reg >= 6'(DATA_START))
                     rdat_reg <= {rdat_reg[14:0], mdio_s[1]};
               end
            end
            HS_HIGH:
            begin
               ph_reg <= ph_reg + 1'b1;
               if (ph_reg == PH_W'(MDC_HALF_CYC - 1))
               begin
                  ph_reg <= '0;
                  mdc_reg <= 1'b0;
                  fr_reg <= {fr_reg[FRAME_BITS-2:0], 1'b1};
                  idx_reg <= idx_reg + 1'b1;
                  hs_reg <= HS_LOW;
                  if (idx_reg == 6'(FRAME_BITS - 1))
                  begin
                     // [RL2] Release when frame ends
                     oe_reg <= 1'b0;
                     done <= 1'b1;
                     hs_reg <= HS_IDLE;
                  end
               end
            end
            default:
               hs_reg <= HS_IDLE;
         endcase
      end
   end

   // [RL8] Reset pin hold and [RL12] wake pulse
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_cnt_reg <= '0;
         wk_cnt_reg <= '0;
      end
      else
      begin
         if (wr && addr == H_PIN && wdata[PIN_RST])
            rst_cnt_reg <= RS_W'(RST_MIN_CYC);
         else if (rst_cnt_reg != '0)
            rst_cnt_reg <= rst_cnt_reg - 1'b1;
         if (wr && addr == H_PIN && wdata[PIN_WAKE])
            wk_cnt_reg <= WK_W'(WAKE_PULSE_CYC);
         else if (wk_cnt_reg != '0)
            wk_cnt_reg <= wk_cnt_reg - 1'b1;
      end
   end

   // Device interrupt level seen through polarity
   assign dev_act = pol_reg ? int_s[1] : ~int_s[1];
   assign set = {dev_act, done};
   assign clr = (wr && addr == H_IRQ) ? wdata[1:0] : 2'h0;

   // Station status, mask and polarity
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stat_reg <= 2'h0;
         mask_reg <= 2'h0;
         pol_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         stat_reg <= (stat_reg & ~clr) | set;
         irq_reg <= |(stat_reg & mask_reg);
         if (wr && addr == H_MASK)
            mask_reg <= wdata[1:0];
         if (wr && addr == H_PIN)
            pol_reg <= wdata[PIN_POL];
      end
   end

   // Register read port, data one cycle later
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_reg <= 32'h0000_0000;
      else if (!rd)
         rdata_reg <= 32'h0000_0000;
      else if (addr == H_STAT)
         rdata_reg <= {15'h0000, hs_reg != HS_IDLE, rdat_reg};
      else if (addr == H_IRQ)
         rdata_reg <= {30'h0000_0000, stat_reg};
      else if (addr == H_MASK)
         rdata_reg <= {30'h0000_0000, mask_reg};
      else if (addr == H_PIN)
         rdata_reg <= {29'h0000_0000, pol_reg, wk_cnt_reg != '0, rst_cnt_reg != '0};
      else
         rdata_reg <= 32'h0000_0000;
   end

   assign lnk.mdc = mdc_reg;
   assign lnk.sta_mdio_o = 1'b0;
   assign lnk.sta_mdio_oe = oe_reg;
   assign lnk.rst_pin_n = rst_cnt_reg == '0;
   assign lnk.wake_pin = wk_cnt_reg != '0;
   assign rdata = rdata_reg;
   assign irq = irq_reg;
endmodule // pcp_sta_end

// [verification/pcp_link_assertions.sv]
`timescale 1ns/1ps
module pcp_link_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mdc,
   input wire logic sta_mdio_oe,
   input wire logic dev_mdio_o,
   input wire logic dev_mdio_oe,
   input wire logic dev_int_o,
   input wire logic dev_int_oe,
   input wire logic rst_pin_n,
   input wire logic wake_pin,
   input wire logic hold_o,
   input wire logic hold_oe
);
   import pcp_pkg::*;
   int low_cnt;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Low cycles of the device reset pin
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         low_cnt <= 0;
      else
         low_cnt <= rst_pin_n ? 0 : low_cnt + 1;
   end
   // Ten high samples of the station clock
   sequence mdc_high_s;
      mdc [*5] ##1 mdc [*5];
   endsequence
   od_low_a: assert property (!dev_mdio_o && !dev_int_o)
      else $error("open-drain pin driven high");
   one_driver_a: assert property (!(sta_mdio_oe && dev_mdio_oe))
      else $error("both ends pull data line");
   mdc_phase_a: assert property ($rose(mdc) |-> mdc_high_s ##1 !mdc)
      else $error("station clock half period wrong");
   dev_launch_a: assert property ($changed(dev_mdio_oe) |-> mdc && $past(mdc, 2))
      else $error("device data changed off clock");
   sta_launch_a: assert property ($changed(sta_mdio_oe) |-> !mdc)
      else $error("station data changed while clock high");
   hold_level_a: assert property (hold_oe |-> hold_o)
      else $error("hold output driven low");
   wake_width_a: assert property ($rose(hold_oe) && rst_pin_n |-> $past(wake_pin, 40))
      else $error("woke on short pulse");
   rst_width_a: assert property ($rose(rst_pin_n) |-> low_cnt >= RST_MIN_CYC)
      else $error("reset pin pulse too short");
   pin_rst_int_a: assert property ($rose(rst_pin_n) |-> ##8 !dev_int_oe)
      else $error("interrupt not back to default");
endmodule // pcp_link_assertions

// [verification/phy_control_pins_tb_top.sv]
`timescale 1ns/1ps
module phy_control_pins_tb_top;
   import pcp_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, link_up = 1, activity = 0;
   logic sleep_req = 0, addr_strap_pin = 1;
   logic [7:0] addr = 0, evt_in = 0;
   logic [31:0] wdata = 0, rdata, v;
   logic sta_irq, dev_irq, link_lamp, activity_lamp, in_sleep, pin_reset_active;
   logic [4:0] station_addr_bits;
   logic [4:0] pa = 5'h01;
   logic [15:0] q;
   int n_errors = 0;
   int samples_checked = 0;
   int n1;
   pcp_link_if lnk();
   pcp_dev_end #(.BLINK_CYC(20)) pcp_dev_end_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk.dev),
      .evt_in(evt_in), .link_up(link_up), .activity(activity), .sleep_req(sleep_req),
      .addr_strap_pin(addr_strap_pin), .irq(dev_irq), .link_lamp(link_lamp),
      .activity_lamp(activity_lamp), .in_sleep(in_sleep),
      .pin_reset_active(pin_reset_active), .station_addr_bits(station_addr_bits));
   pcp_sta_end pcp_sta_end_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk.sta), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(sta_irq));
   pcp_link_assertions pcp_link_assertions_inst (.clk(clk), .rst_n(rst_n), .mdc(lnk.mdc),
      .sta_mdio_oe(lnk.sta_mdio_oe), .dev_mdio_o(lnk.dev_mdio_o),
      .dev_mdio_oe(lnk.dev_mdio_oe), .dev_int_o(lnk.dev_int_o), .dev_int_oe(lnk.dev_int_oe),
      .rst_pin_n(lnk.rst_pin_n), .wake_pin(lnk.wake_pin), .hold_o(lnk.hold_o),
      .hold_oe(lnk.hold_oe));
   // Core clock
   always #12.5 clk = ~clk;
   // Bus write, one strobe cycle
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   // Bus read, data taken in the next cycle
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 v = rdata;
   endtask
   // Waits edges, then lets them settle
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", s, e, g);
         n_errors++;
      end
   endtask
   // Management frame, polled until idle
   task automatic frame(input logic w, input logic [4:0] r, input logic [15:0] d);
      wreg(H_CMD, {5'h00, pa, w, r, d});
      repeat (2000)
      begin
         rreg(H_STAT);
         if (v[STAT_BUSY_BIT] === 1'b0)
            break;
      end
      chk("busy", 16'h0000, 16'(v[STAT_BUSY_BIT]));
      q = v[15:0];
   endtask
   // Strap address, lamp and foreign frames
   task automatic t_ident();
      chk("addr", 16'h0001, 16'(station_addr_bits));
      chk("link_lamp", 16'h0001, 16'(link_lamp));
      frame(0, REG_DEV_STAT, 16'h0000);
      chk("dev_stat", 16'h0021, q);
      pa = 5'h02;
      frame(0, REG_DEV_STAT, 16'h0000);
      chk("foreign", 16'hFFFF, q);
      pa = 5'h01;
   endtask
   // Enable, sticky flag, clear, polarity
   task automatic t_irq();
      frame(0, REG_INT_EN, 16'h0000);
      chk("int_en", 16'h0000, q);
      @(posedge clk);
      evt_in <= 8'h08;
      @(posedge clk);
      evt_in <= 8'h00;
      tick(4);
      chk("int_off", 16'h0001, 16'(lnk.int_line));
      frame(0, REG_INT_STAT, 16'h0000);
      chk("int_stat", 16'h0008, q);
      frame(1, REG_INT_EN, 16'h0008);
      tick(4);
      chk("int_on", 16'h0000, 16'(lnk.int_line));
      chk("dev_irq", 16'h0001, 16'(dev_irq));
      chk("sta_irq", 16'h0000, 16'(sta_irq));
      wreg(H_MASK, 32'h0000_0002);
      tick(3);
      chk("sta_irq", 16'h0001, 16'(sta_irq));
      frame(1, REG_INT_STAT, 16'h0008);
      tick(4);
      chk("int_clr", 16'h0001, 16'(lnk.int_line));
      chk("dev_irq_clr", 16'h0000, 16'(dev_irq));
      wreg(H_IRQ, 32'h0000_0002);
      tick(3);
      chk("sta_clr", 16'h0000, 16'(sta_irq));
      frame(1, REG_INT_CFG, 16'h0001);
      tick(4);
      chk("int_pol", 16'h0000, 16'(lnk.int_line));
   endtask
   // Pin reset reloads straps and defaults
   task automatic t_pinrst();
      @(posedge clk);
      addr_strap_pin <= 0;
      wreg(H_PIN, 32'h0000_0001);
      repeat (600)
      begin
         tick(1);
         if (pin_reset_active === 1'b1)
            break;
      end
      chk("pin_rst", 16'h0001, 16'(pin_reset_active));
      tick(20);
      chk("strap", 16'h0000, 16'(station_addr_bits));
      chk("int_dflt", 16'h0001, 16'(lnk.int_line));
      pa = 5'h00;
      frame(0, REG_INT_CFG, 16'h0000);
      chk("cfg_dflt", 16'h0000, q);
   endtask
   // Sleep releases hold, wake pulse returns
   task automatic t_sleep();
      @(posedge clk);
      sleep_req <= 1;
      @(posedge clk);
      sleep_req <= 0;
      tick(3);
      chk("sleep", 16'h0001, 16'(in_sleep));
      chk("hold_off", 16'h0000, 16'(lnk.hold_line));
      wreg(H_PIN, 32'h0000_0002);
      tick(20);
      chk("wake_early", 16'h0001, 16'(in_sleep));
      repeat (200)
      begin
         tick(1);
         if (in_sleep === 1'b0)
            break;
      end
      chk("woke", 16'h0000, 16'(in_sleep));
      tick(1);
      chk("hold_on", 16'h0001, 16'(lnk.hold_line));
   endtask
   // Activity blink and link loss
   task automatic t_lamp();
      n1 = 0;
      @(posedge clk);
      activity <= 1;
      repeat (80)
      begin
         tick(1);
         if (activity_lamp === 1'b1)
            n1++;
      end
      chk("blink", 16'h0001, 16'(n1 > 10 && n1 < 70));
      @(posedge clk);
      link_up <= 0;
      tick(3);
      chk("lamps", 16'h0000, {14'h0000, link_lamp, activity_lamp});
   endtask
   task automatic final_report();
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      tick(4);
      t_ident();
      t_irq();
      t_pinrst();
      t_sleep();
      t_lamp();
      final_report();
   end
   // Watchdog
   initial
   begin
      #2_000_000;
      n_errors++;
      final_report();
   end
endmodule // phy_control_pins_tb_top
